// File: verilog/dcc_pkg.sv
package dcc_pkg;

  // Special function register addresses
  localparam logic [7:0] DCC_ADDR_PORT0    = 8'h80;
  localparam logic [7:0] DCC_ADDR_GLB_IE   = 8'ha8;
  localparam logic [7:0] DCC_ADDR_CMP_IE   = 8'he8;
  localparam logic [7:0] DCC_ADDR_DIN_DIS  = 8'hf6;
  localparam logic [7:0] DCC_ADDR_CMP_ONE  = 8'hac;
  localparam logic [7:0] DCC_ADDR_CMP_TWO  = 8'had;

  // Comparator control register fields
  localparam int DCC_BIT_ENABLE = 5;
  localparam int DCC_BIT_POS    = 4;
  localparam int DCC_BIT_NEG    = 3;
  localparam int DCC_BIT_OE     = 2;
  localparam int DCC_BIT_RESULT = 1;
  localparam int DCC_BIT_FLAG   = 0;

  // Interrupt enable fields
  localparam int DCC_BIT_GIE    = 7;
  localparam int DCC_BIT_IE_ONE = 5;
  localparam int DCC_BIT_IE_TWO = 2;

  // Values after reset
  localparam logic [7:0] DCC_RST_DIN_DIS = 8'h00;
  localparam logic [7:0] DCC_RST_RDATA   = 8'h00;

  // Start-up settling time that software waits out after enabling
  localparam int DCC_CLK_MHZ        = 10;
  localparam int DCC_STARTUP_US     = 10;
  localparam int DCC_STARTUP_CYCLES = DCC_STARTUP_US * DCC_CLK_MHZ;

  typedef struct packed {
    logic enable;
    logic pos_sel;
    logic neg_sel;
    logic out_en;
    logic flag;
  } dcc_ctrl_type;

  localparam dcc_ctrl_type DCC_RST_CTRL = '0;

  function automatic logic [7:0] dcc_ctrl_addr(input int idx);
    dcc_ctrl_addr = (idx == 0) ? DCC_ADDR_CMP_ONE : DCC_ADDR_CMP_TWO;
  endfunction : dcc_ctrl_addr

  function automatic int dcc_ie_bit(input int idx);
    dcc_ie_bit = (idx == 0) ? DCC_BIT_IE_ONE : DCC_BIT_IE_TWO;
  endfunction : dcc_ie_bit

endpackage : dcc_pkg

// File: verilog/dcc_sync.sv
`timescale 1ns/1ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  if (WIDTH < 1) begin : g_bad_width
    $error("dcc_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage_one   <= '0;
      stage_two   <= '0;
      stage_three <= '0;
    end else begin
      stage_one   <= i_async;
      stage_two   <= stage_one;
      stage_three <= stage_two;
    end
  end

  // A bit moves only once the last two stages agree, masking glitches
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sync <= '0;
    end else begin
      o_sync <= (stage_two & stage_three) | (o_sync & (stage_two | stage_three));
    end
  end

endmodule : dcc_sync

// File: verilog/dcc_top.sv
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_hit,
  input  wire logic [7:0] i_port0_pin,
  input  wire logic [1:0] i_cmp_raw,
  output logic      [7:0] o_port0_din_disable,
  output logic      [1:0] o_cmp_enable,
  output logic      [1:0] o_cmp_pos_sel,
  output logic      [1:0] o_cmp_neg_sel,
  output logic      [1:0] o_cmp_pin,
  output logic      [1:0] o_cmp_pin_oe,
  output logic      [1:0] o_cmp_irq,
  output logic            o_wake
);

  dcc_ctrl_type ctrl [2];
  logic [1:0]   result;
  logic [1:0]   cmp_sync;
  logic [1:0]   set_evt;
  logic [1:0]   wr_ctrl;
  logic [1:0]   int_en;
  logic         gie;
  logic [7:0]   port_sync;
  logic [7:0]   din_dis;
  logic [7:0]   next_rdata;
  logic         next_hit;
  logic [1:0]   irq_req;

  // The analog comparator output is asynchronous to the CPU clock
  dcc_sync #(.WIDTH(2)) u_cmp_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_cmp_raw),
    .o_sync    (cmp_sync)
  );

  dcc_sync #(.WIDTH(8)) u_port_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_port0_pin),
    .o_sync    (port_sync)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      din_dis <= DCC_RST_DIN_DIS;
    end else if (i_sfr_wr && i_sfr_addr == DCC_ADDR_DIN_DIS) begin
      din_dis <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_en <= 2'h0;
      gie    <= 1'b0;
    end else begin
      if (i_sfr_wr && i_sfr_addr == DCC_ADDR_CMP_IE) begin
        int_en[0] <= i_sfr_wdata[dcc_ie_bit(0)];
        int_en[1] <= i_sfr_wdata[dcc_ie_bit(1)];
      end
      if (i_sfr_wr && i_sfr_addr == DCC_ADDR_GLB_IE) begin
        gie <= i_sfr_wdata[DCC_BIT_GIE];
      end
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_cmp
    assign wr_ctrl[i] = i_sfr_wr && i_sfr_addr == dcc_ctrl_addr(i);
    // A disabled comparator reads zero, so it cannot raise the flag
    assign set_evt[i] = ctrl[i].enable && cmp_sync[i] != result[i];

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        result[i] <= 1'b0;
      end else begin
        result[i] <= ctrl[i].enable & cmp_sync[i];
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        ctrl[i] <= DCC_RST_CTRL;
      end else if (wr_ctrl[i]) begin
        ctrl[i].enable  <= i_sfr_wdata[DCC_BIT_ENABLE];
        ctrl[i].pos_sel <= i_sfr_wdata[DCC_BIT_POS];
        ctrl[i].neg_sel <= i_sfr_wdata[DCC_BIT_NEG];
        ctrl[i].out_en  <= i_sfr_wdata[DCC_BIT_OE];
        // Writing one keeps the flag; a change in the same cycle wins
        ctrl[i].flag    <= set_evt[i] |
                           (ctrl[i].flag & i_sfr_wdata[DCC_BIT_FLAG]);
      end else begin
        ctrl[i].flag    <= ctrl[i].flag | set_evt[i];
      end
    end

    assign irq_req[i] = ctrl[i].flag & int_en[i] & gie;
    assign o_cmp_enable[i]  = ctrl[i].enable;
    assign o_cmp_pos_sel[i] = ctrl[i].pos_sel;
    assign o_cmp_neg_sel[i] = ctrl[i].neg_sel;
    assign o_cmp_pin_oe[i]  = ctrl[i].out_en;
  end

  // No clock gating here: in idle and power-down the block must still see
  // a clock, since the synchronisers need it to notice the change
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmp_irq <= 2'h0;
      o_wake    <= 1'b0;
      o_cmp_pin <= 2'h0;
    end else begin
      o_cmp_irq <= irq_req;
      o_wake    <= |irq_req;
      o_cmp_pin <= result & {ctrl[1].out_en, ctrl[0].out_en};
    end
  end

  assign o_port0_din_disable = din_dis;

  always_comb begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    if (i_sfr_addr == DCC_ADDR_PORT0) begin
      next_rdata = port_sync & ~din_dis;
    end else if (i_sfr_addr == DCC_ADDR_DIN_DIS) begin
      next_rdata = din_dis;
    end else if (i_sfr_addr == DCC_ADDR_GLB_IE) begin
      next_rdata[DCC_BIT_GIE] = gie;
    end else if (i_sfr_addr == DCC_ADDR_CMP_IE) begin
      next_rdata[DCC_BIT_IE_ONE] = int_en[0];
      next_rdata[DCC_BIT_IE_TWO] = int_en[1];
    end else if (i_sfr_addr == DCC_ADDR_CMP_ONE ||
                 i_sfr_addr == DCC_ADDR_CMP_TWO) begin
      for (int k = 0; k < 2; k++) begin
        if (i_sfr_addr == dcc_ctrl_addr(k)) begin
          next_rdata[DCC_BIT_ENABLE] = ctrl[k].enable;
          next_rdata[DCC_BIT_POS]    = ctrl[k].pos_sel;
          next_rdata[DCC_BIT_NEG]    = ctrl[k].neg_sel;
          next_rdata[DCC_BIT_OE]     = ctrl[k].out_en;
          next_rdata[DCC_BIT_RESULT] = result[k];
          next_rdata[DCC_BIT_FLAG]   = ctrl[k].flag;
        end
      end
    end else begin
      next_hit = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sfr_rdata <= DCC_RST_RDATA;
      o_sfr_hit   <= 1'b0;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= next_rdata;
      o_sfr_hit   <= next_hit;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  for (genvar i = 0; i < 2; i++) begin : g_chk
    a_flag_on_change:
      assert property (ctrl[i].enable && cmp_sync[i] != result[i]
                       |=> ctrl[i].flag && result[i] == $past(cmp_sync[i]))
      else $error("change flag not set on output change");
    a_flag_holds:
      assert property (ctrl[i].flag &&
                       !(wr_ctrl[i] && !i_sfr_wdata[DCC_BIT_FLAG])
                       |=> ctrl[i].flag)
      else $error("change flag dropped without a zero write");
    a_flag_clears:
      assert property (wr_ctrl[i] && !i_sfr_wdata[DCC_BIT_FLAG] &&
                       !set_evt[i] |=> !ctrl[i].flag)
      else $error("change flag not cleared by zero write");
    a_irq_gated:
      assert property (o_cmp_irq[i] ==
                       $past(ctrl[i].flag & int_en[i] & gie))
      else $error("interrupt request not gated by both enables");
    a_off_reads_zero:
      assert property (!ctrl[i].enable |=> !result[i] ##1 !o_cmp_pin[i])
      else $error("disabled comparator shows a one");
    a_sel_follows:
      assert property (wr_ctrl[i] |=> ctrl[i].pos_sel ==
                       $past(i_sfr_wdata[DCC_BIT_POS]) &&
                       ctrl[i].neg_sel == $past(i_sfr_wdata[DCC_BIT_NEG]))
      else $error("input select not taken from write");
  end

  a_port_masked:
    assert property (i_sfr_rd && i_sfr_addr == DCC_ADDR_PORT0 |=>
                     (o_sfr_rdata & $past(din_dis)) == 8'h00)
    else $error("disabled port bit read as one");
  a_disable_write:
    assert property (i_sfr_wr && i_sfr_addr == DCC_ADDR_DIN_DIS |=>
                     o_port0_din_disable == $past(i_sfr_wdata))
    else $error("input disable register not written");
  a_wake_follows:
    assert property (o_wake == |o_cmp_irq)
    else $error("wake does not follow interrupt request");

endmodule : dcc_top

// File: test/dcc_pin_model.sv
`timescale 1ns/1ps
module dcc_pin_model
  import dcc_pkg::*;
(
  input  wire logic                  i_sys_clk,
  input  wire logic [1:0]            i_enable,
  input  wire logic [1:0]            i_pos_sel,
  input  wire logic [1:0]            i_neg_sel,
  input  wire logic [1:0][3:0][11:0] i_mv,
  output logic      [1:0]            o_raw
);
  logic [1:0] idle_pat = 2'b01;

  // A powered-down comparator gives no usable level, so it wanders
  always @(negedge i_sys_clk) idle_pat <= ~idle_pat;

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      o_raw[n] = idle_pat[n];
      if (i_enable[n]) begin
        o_raw[n] = i_mv[n][{1'b0, i_pos_sel[n]}]
                   > i_mv[n][{1'b1, i_neg_sel[n]}];
      end
    end
  end
endmodule : dcc_pin_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dcc_pkg::*;
  logic                  clk, rst_b, wr, rd, hit, wake;
  logic [7:0]            addr, wdata, rdata, pins, din_dis;
  logic [1:0]            raw, en, pos, neg, cpin, oe, irq;
  logic [1:0][3:0][11:0] mv;
  int                    bad_count = 0;
  int                    compares = 0;
  int                    cycles = 0;

  dcc_top u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .o_sfr_hit(hit), .i_port0_pin(pins), .i_cmp_raw(raw),
    .o_port0_din_disable(din_dis), .o_cmp_enable(en), .o_cmp_pos_sel(pos),
    .o_cmp_neg_sel(neg), .o_cmp_pin(cpin), .o_cmp_pin_oe(oe),
    .o_cmp_irq(irq), .o_wake(wake));

  dcc_pin_model u_pins (.i_sys_clk(clk), .i_enable(en), .i_pos_sel(pos),
    .i_neg_sel(neg), .i_mv(mv), .o_raw(raw));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : sfr_rd

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic complete_run();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    logic [7:0] d;
    logic [7:0] a;
    logic [2:0] c;
    logic       e;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pins = 8'hff;
    rst_b = 1'b0;
    // Per comparator: internal ref, ref pin, pin B, pin A
    mv[0] = {12'd1280, 12'd600, 12'd1500, 12'd900};
    mv[1] = mv[0];
    idle(5);
    rst_b = 1'b1;
    sfr_rd(DCC_ADDR_DIN_DIS, d);
    chk(d, 8'h00);
    chk(din_dis, 8'h00);
    sfr_wr(DCC_ADDR_DIN_DIS, 8'h30);
    idle(5);
    sfr_rd(DCC_ADDR_PORT0, d);
    chk(d, 8'hcf);
    chk({7'h00, hit}, 8'h01);
    chk(din_dis, 8'h30);
    sfr_rd(8'h81, d);
    chk({d[7:1], hit}, 8'h00);
    for (int n = 0; n < 2; n++) begin
      a = n ? DCC_ADDR_CMP_TWO : DCC_ADDR_CMP_ONE;
      for (int k = 0; k < 8; k++) begin
        c = 3'(k);
        e = mv[n][{1'b0, c[2]}] > mv[n][{1'b1, c[1]}];
        sfr_wr(a, {3'b001, c, 2'b00});
        idle(DCC_STARTUP_CYCLES);
        sfr_rd(a, d);
        chk(d & 8'hfe, {3'b001, c, e, 1'b0});
        chk({3'b000, en[n], pos[n], neg[n], oe[n], cpin[n]},
            {4'b0001, c, e & c[0]});
      end
    end
    sfr_wr(DCC_ADDR_CMP_TWO, 8'h00);
    idle(20);
    sfr_rd(DCC_ADDR_CMP_TWO, d);
    chk(d, 8'h00);
    sfr_wr(DCC_ADDR_CMP_ONE, 8'h24);
    idle(DCC_STARTUP_CYCLES);
    sfr_wr(DCC_ADDR_CMP_ONE, 8'h24);
    sfr_wr(DCC_ADDR_CMP_IE, 8'h20);
    sfr_wr(DCC_ADDR_GLB_IE, 8'h80);
    idle(3);
    chk({5'h00, irq, wake}, 8'h00);
    mv[0][0] = 12'd100;
    idle(8);
    chk({5'h00, irq, wake}, 8'h03);
    chk({6'h00, cpin}, 8'h00);
    idle(30);
    chk({5'h00, irq, wake}, 8'h03);
    sfr_rd(DCC_ADDR_CMP_ONE, d);
    chk(d, 8'h25);
    sfr_wr(DCC_ADDR_GLB_IE, 8'h00);
    idle(2);
    chk({5'h00, irq, wake}, 8'h00);
    sfr_wr(DCC_ADDR_GLB_IE, 8'h80);
    idle(2);
    chk({5'h00, irq, wake}, 8'h03);
    sfr_wr(DCC_ADDR_CMP_ONE, 8'h24);
    idle(2);
    chk({5'h00, irq, wake}, 8'h00);
    // Comparator two alone must drive its own request line
    sfr_wr(DCC_ADDR_CMP_TWO, 8'h20);
    idle(DCC_STARTUP_CYCLES);
    sfr_wr(DCC_ADDR_CMP_TWO, 8'h20);
    sfr_wr(DCC_ADDR_CMP_IE, 8'h04);
    idle(3);
    chk({5'h00, irq, wake}, 8'h00);
    mv[1][0] = 12'd100;
    idle(8);
    chk({5'h00, irq, wake}, 8'h05);
    complete_run();
  end
endmodule : testbench
